// >>> rtl/mcd_modem_change.sv
`timescale 1ns/1ps
module mcd_modem_change
    import mcd_pkg::*;
(
    input  wire logic          CLK,
    input  wire logic          RST,
    input  wire mcd_bus_req_t  BUS,
    output logic [7:0]         RDATA,
    input  wire mcd_modem_in_t PIN_N,
    input  wire logic [3:0]    RX_FILL,
    output logic               DTR_N,
    output logic               RTS_N,
    output logic               SRQ,
    output logic               IRQ
);
    logic [2:0] sync1_r, sync2_r, prev_r;
    logic [1:0] warm_r;
    logic [7:0] opt1_r, opt1_nxt, opt2_r, opt2_nxt, flags_r, flags_nxt;
    logic [7:0] rd_r, rd_nxt, stat_r, stat_nxt, mask_r, mask_nxt;
    logic [2:0] srq_en_r, srq_en_nxt;
    logic [1:0] ctl_r, ctl_nxt;
    logic       srq_r, srq_nxt, dtr_n_r, dtr_n_nxt, irq_r, irq_nxt;
    logic [2:0] val, rise, fall, hit;
    logic [7:0] sv;
    logic [7:0] ev;

    always_ff @(posedge CLK) begin
        if (RST) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            prev_r  <= 3'h0;
            warm_r  <= 2'h0;
        end else begin
            sync1_r <= ~PIN_N;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
            // edges count only once the previous value holds a real pin sample
            warm_r  <= (warm_r == WARM_DONE) ? WARM_DONE : warm_r + 2'h1;
        end
    end

    always_comb begin
        val  = sync2_r;
        rise = val & ~prev_r;
        fall = ~val & prev_r;
        hit  = ((rise & opt1_r[7:5]) | (fall & opt2_r[7:5])) & {3{warm_r == WARM_DONE}};
        sv   = {val, 3'h0, ~dtr_n_r, ctl_r[BIT_RTS]};
        opt1_nxt   = opt1_r;
        opt2_nxt   = opt2_r;
        flags_nxt  = flags_r;
        srq_en_nxt = srq_en_r;
        ctl_nxt    = ctl_r;
        mask_nxt   = mask_r;
        srq_nxt    = srq_r;
        stat_nxt   = stat_r;
        ev         = 8'h00;
        rd_nxt     = 8'h00;
        if (BUS.wr) begin
            unique case (BUS.addr)
                ADDR_OPT_ONE:  opt1_nxt   = BUS.wdata & 8'hEF;
                ADDR_OPT_TWO:  opt2_nxt   = BUS.wdata & WATCH_MASK;
                ADDR_FLAGS:    flags_nxt  = BUS.wdata & WATCH_MASK;
                ADDR_SIG_VAL:  ctl_nxt    = BUS.wdata[1:0];
                ADDR_IRQ_STAT: stat_nxt   = stat_r & ~BUS.wdata;
                ADDR_IRQ_MASK: mask_nxt   = BUS.wdata;
                ADDR_SRQ_EN:   srq_en_nxt = BUS.wdata[7:5];
                ADDR_END_SVC:  srq_nxt    = 1'b0;
                default: ;
            endcase
        end
        if (!srq_r) begin
            flags_nxt[7:5] = flags_nxt[7:5] | hit;
            if (|(hit & srq_en_r)) begin
                srq_nxt = 1'b1;
            end
        end
        ev[IRQ_CHANGE] = !srq_r && |hit;
        ev[IRQ_SRQ]    = srq_nxt && !srq_r;
        stat_nxt = stat_nxt | ev;
        if (BUS.rd) begin
            unique case (BUS.addr)
                ADDR_OPT_ONE:  rd_nxt = opt1_r;
                ADDR_OPT_TWO:  rd_nxt = opt2_r;
                ADDR_FLAGS:    rd_nxt = flags_r & WATCH_MASK;
                ADDR_SIG_VAL:  rd_nxt = sv;
                ADDR_IRQ_STAT: rd_nxt = stat_r;
                ADDR_IRQ_MASK: rd_nxt = mask_r;
                ADDR_SRQ_EN:   rd_nxt = {srq_en_r, 4'h0, srq_r};
                default:       rd_nxt = 8'h00;
            endcase
        end
        // auto terminal ready: off when threshold zero, else follows receive fill
        if (opt1_r[3:0] == THR_OFF) begin
            dtr_n_nxt = ~ctl_r[BIT_DTR];
        end else begin
            dtr_n_nxt = (RX_FILL >= opt1_r[3:0]);
        end
        irq_nxt = |(stat_nxt & mask_nxt);
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            opt1_r   <= RESET_VAL;
            opt2_r   <= RESET_VAL;
            flags_r  <= RESET_VAL;
            srq_en_r <= 3'h0;
            ctl_r    <= 2'h0;
            mask_r   <= RESET_VAL;
            stat_r   <= RESET_VAL;
            srq_r    <= 1'b0;
            rd_r     <= RESET_VAL;
            dtr_n_r  <= 1'b1;
            irq_r    <= 1'b0;
            RTS_N    <= 1'b1;
        end else begin
            opt1_r   <= opt1_nxt;
            opt2_r   <= opt2_nxt;
            flags_r  <= flags_nxt;
            srq_en_r <= srq_en_nxt;
            ctl_r    <= ctl_nxt;
            mask_r   <= mask_nxt;
            stat_r   <= stat_nxt;
            srq_r    <= srq_nxt;
            rd_r     <= rd_nxt;
            dtr_n_r  <= dtr_n_nxt;
            irq_r    <= irq_nxt;
            RTS_N    <= ~ctl_nxt[BIT_RTS];
        end
    end

    assign RDATA = rd_r;
    assign DTR_N = dtr_n_r;
    assign SRQ   = srq_r;
    assign IRQ   = irq_r;
endmodule

// >>> rtl/mcd_pkg.sv
// Contract
// - a level change on a watched modem input that matches a selected transition sets its change flag.
// - change flags sit at bit 7 (data set ready), bit 6 (carrier detect) and bit 5 (clear to send); bits 4:0 read zero.
// - a detected change raises the modem service request only when its service request enable is set.
// - once the service request is raised the change flags stop updating until end of service is written.
// - option one bit 7 selects detection of a zero-to-one change of the data set ready value bit.
// - option one bits 6 and 5 select zero-to-one detection on carrier detect and clear to send.
// - option one bits 3:0 hold the automatic terminal ready threshold; zero turns the feature off.
// - a nonzero threshold is a binary count of received characters.
// - signal value bits are inverted against the active-low pins.
// - option two bits 7, 6 and 5 select one-to-zero detection on the three inputs.
package mcd_pkg;
    localparam logic [7:0] ADDR_OPT_ONE   = 8'h10;
    localparam logic [7:0] ADDR_OPT_TWO   = 8'h11;
    localparam logic [7:0] ADDR_FLAGS     = 8'h12;
    localparam logic [7:0] ADDR_SIG_VAL   = 8'h28;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h30;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h31;
    localparam logic [7:0] ADDR_SRQ_EN    = 8'h32;
    localparam logic [7:0] ADDR_END_SVC   = 8'h33;
    localparam logic [7:0] RESET_VAL      = 8'h00;
    localparam int         BIT_DSR        = 7;
    localparam int         BIT_CD         = 6;
    localparam int         BIT_CTS        = 5;
    localparam int         BIT_DTR        = 1;
    localparam int         BIT_RTS        = 0;
    localparam logic [7:0] WATCH_MASK     = 8'hE0;
    localparam logic [3:0] THR_OFF        = 4'h0;
    localparam logic [1:0] WARM_DONE      = 2'h3;
    localparam int         IRQ_CHANGE     = 0;
    localparam int         IRQ_SRQ        = 1;

    typedef struct packed {
        logic dsr;
        logic cd;
        logic cts;
    } mcd_modem_in_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } mcd_bus_req_t;
endpackage

// >>> test/mcd_modem_model.sv
`timescale 1ns/1ps
module mcd_modem_model
    import mcd_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic [2:0] LEVEL,
    output mcd_modem_in_t   PIN_N
);
    // an asserted line shows as a low pin, changed just after an edge
    always_ff @(posedge CLK) PIN_N <= mcd_modem_in_t'(~LEVEL);
endmodule

// >>> test/mcd_modem_change_properties.sv
`timescale 1ns/1ps
module mcd_props
    import mcd_pkg::*;
(
    input  wire logic          CLK,
    input  wire logic          RST,
    input  wire mcd_bus_req_t  BUS,
    input  wire logic [7:0]    RDATA,
    input  wire mcd_modem_in_t PIN_N,
    input  wire logic          DTR_N,
    input  wire logic          SRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    wire eos = BUS.wr && BUS.addr == ADDR_END_SVC;
    sequence s_rd(a); $past(BUS.rd) && $past(BUS.addr) == a; endsequence
    property p_flags_low; s_rd(ADDR_FLAGS) |-> RDATA[4:0] == 5'h00; endproperty
    property p_opt_bit4; s_rd(ADDR_OPT_ONE) |-> RDATA[4] == 1'b0; endproperty
    property p_two_low; s_rd(ADDR_OPT_TWO) |-> RDATA[4:0] == 5'h00; endproperty
    property p_sig_low; s_rd(ADDR_SIG_VAL) |-> RDATA[4:2] == 3'h0; endproperty
    property p_srq_hold; SRQ && !eos |=> SRQ; endproperty
    property p_srq_eos; $fell(SRQ) |-> $past(eos); endproperty
    property p_srq_cause; $rose(SRQ) |-> $past(PIN_N, 5) != $past(PIN_N, 2); endproperty
    property p_rst_out; $past(RST) |-> !SRQ && DTR_N; endproperty
    a_flags_low: assert property (p_flags_low) else $error("flag low bits set");
    a_opt_bit4: assert property (p_opt_bit4) else $error("option bit 4 set");
    a_two_low: assert property (p_two_low) else $error("option two low bits set");
    a_sig_low: assert property (p_sig_low) else $error("unused value bits set");
    a_srq_hold: assert property (p_srq_hold) else $error("request dropped early");
    a_srq_eos: assert property (p_srq_eos) else $error("request fell without end");
    a_srq_cause: assert property (p_srq_cause) else $error("request without pin change");
    a_rst_out: assert property (p_rst_out) else $error("outputs not reset");
endmodule
bind mcd_modem_change mcd_props i_mcd_props (.CLK(CLK), .RST(RST), .BUS(BUS), .RDATA(RDATA), .PIN_N(PIN_N),
    .DTR_N(DTR_N), .SRQ(SRQ));

// >>> test/modem_change_detect_auto_dtr_tb.sv
`timescale 1ns/1ps
module modem_change_detect_auto_dtr_tb
    import mcd_pkg::*;
;
    logic clk = 0, rst = 1, dtr_n, rts_n, srq, irq;
    logic [2:0] lvl = 3'b001;
    logic [3:0] fill = 4'h0;
    logic [7:0] rdata;
    mcd_bus_req_t bus = '0;
    mcd_modem_in_t pin_n;
    int num_errors = 0, checks_done = 0, cyc = 0;
    logic [23:0] rows [11] = '{24'h10FFEF, 24'h11FFE0, 24'h12FFE0, 24'h120000, 24'h05FF00, 24'h100000, 24'h110000,
        24'h32E0E0, 24'h320000, 24'h31FFFF, 24'h310000};
    logic [11:0] dtr_rows [5] = '{12'h320, 12'h331, 12'h030, 12'h111, 12'hFE0};
    mcd_modem_change i_mcd_modem_change (.CLK(clk), .RST(rst), .BUS(bus), .RDATA(rdata), .PIN_N(pin_n),
        .RX_FILL(fill), .DTR_N(dtr_n), .RTS_N(rts_n), .SRQ(srq), .IRQ(irq));
    mcd_modem_model i_mcd_modem_model (.CLK(clk), .LEVEL(lvl), .PIN_N(pin_n));
    always #5 clk = ~clk;
    task automatic results;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            results();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        @(posedge clk);
        bus <= '{a, d, w, !w};
        @(posedge clk);
        bus <= '0;
        #1;
        if (!w) chk(rdata, e);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    initial begin
        wait_n(12);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++) acc(0, ADDR_OPT_ONE + 8'(i), 8'h00, 8'h00);
        foreach (rows[i]) begin
            acc(1, rows[i][23:16], rows[i][15:8], 8'h00);
            acc(0, rows[i][23:16], 8'h00, rows[i][7:0]);
        end
        acc(1, ADDR_OPT_ONE, 8'hC0, 8'h00);
        acc(1, ADDR_SRQ_EN, 8'h80, 8'h00);
        acc(1, ADDR_OPT_TWO, 8'h20, 8'h00);
        lvl <= 3'b101;
        wait_n(8);
        chk({6'h00, srq, irq}, 8'h02);
        lvl <= 3'b111;
        wait_n(8);
        acc(0, ADDR_FLAGS, 8'h00, 8'h80);
        acc(1, ADDR_IRQ_MASK, 8'h01, 8'h00);
        wait_n(2);
        chk({7'h00, irq}, 8'h01);
        acc(1, ADDR_FLAGS, 8'h00, 8'h00);
        acc(1, ADDR_IRQ_STAT, 8'h03, 8'h00);
        acc(1, ADDR_END_SVC, 8'h00, 8'h00);
        wait_n(2);
        chk({6'h00, srq, irq}, 8'h00);
        lvl <= 3'b110;
        wait_n(8);
        acc(0, ADDR_FLAGS, 8'h00, 8'h20);
        chk({6'h00, srq, irq}, 8'h01);
        acc(0, ADDR_IRQ_STAT, 8'h00, 8'h01);
        acc(0, ADDR_SIG_VAL, 8'h00, 8'hC0);
        acc(1, ADDR_SIG_VAL, 8'h02, 8'h00);
        chk({7'h00, rts_n}, 8'h01);
        foreach (dtr_rows[i]) begin
            acc(1, ADDR_OPT_ONE, {4'h0, dtr_rows[i][11:8]}, 8'h00);
            fill <= dtr_rows[i][7:4];
            wait_n(3);
            chk({7'h00, dtr_n}, {7'h00, dtr_rows[i][0]});
        end
        acc(1, ADDR_SIG_VAL, 8'h01, 8'h00);
        chk({7'h00, rts_n}, 8'h00);
        rst <= 1'b1;
        wait_n(2);
        rst <= 1'b0;
        acc(0, ADDR_FLAGS, 8'h00, 8'h00);
        chk({6'h00, dtr_n, rts_n}, 8'h03);
        results();
    end
endmodule
